//--- pbc_pin_mux.sv
// Pin function multiplexer for port B pins 48..58 and port C pins 64..79, 85..87.
// Assumes one AHB-Lite master on mclk, pad inputs asynchronous to mclk,
// and peripherals / external interface running on mclk.
// Select changes reach the pads one cycle after the register write lands.
//
// Functional notes
// - Port B pins 48..58: select 00 gives general-purpose I/O, the reset default.
// - Pin 58 select 01 routes serial port A receive clock, bidirectional.
// - Pin 57 select 01 gives SPI-A transmit enable, pin 56 SPI-A clock.
// - Pin 55 select 01 gives SPI-A slave out, pin 54 SPI slave in.
// - Pins 53..50 select 01 give encoder index, strobe, input B, input A.
// - Pin 49 select 01 gives capture channel 6, pin 48 capture channel 5.
// - Port B select 10/11 gives external data lines 21..31, bidirectional.
// - Port C pins 64..79: select 00 or 01 gives general-purpose I/O.
// - Port C pins 64..79 select 10/11: external data lines 15..0, outputs.
// - Pins 85..87 select 10/11 give address lines 13..15 as outputs.
// - Port C lower select fields are read/write and reset to zero.
`timescale 1ns/1ps
`include "pbc_consts.svh"

module pbc_pin_mux
	import pbc_pkg::*;
(
	input  wire logic                  mclk,
	input  wire logic                  arst_n,
	input  wire pbc_ahb_req_t          ahbReq,
	output pbc_ahb_rsp_t               ahbRsp,
	input  wire pbc_pad_drive_t        gpioDrive,
	output logic [`PBC_NPINS-1:0]      gpioIn,
	input  wire pbc_periph_t           periphDat,
	input  wire pbc_periph_t           periphOe,
	output pbc_periph_t                periphIn,
	input  wire pbc_ext_hi_t           extDataHi,
	output logic [`PBC_NB-1:0]         extDataHiIn,
	input  wire logic [`PBC_NCLO-1:0]  extDataLoDat,
	input  wire logic [`PBC_NCUP-1:0]  extAddrDat,
	input  wire logic [`PBC_NPINS-1:0] padIn,
	output pbc_pad_drive_t             padDrive
);

	// =================================================================
	// Select registers and bus data phase state
	logic [31:0]             portBUpperFunctionSelect;
	logic [31:0]             portCLowerFunctionSelect;
	logic [31:0]             portCUpperFunctionSelect;
	logic [31:0]             next_portBUpper;
	logic [31:0]             next_portCLower;
	logic [31:0]             next_portCUpper;
	logic                    dphWrite;
	logic [`PBC_ADDR_W-1:0]  dphAddr;
	logic                    addrAccept;
	logic [31:0]             next_rdata;

	// =================================================================
	// Pad synchroniser and mux results
	logic [`PBC_NPINS-1:0]   padInMeta;
	logic [`PBC_NPINS-1:0]   padInSync;
	logic [`PBC_SEL_W-1:0]   pinSel [`PBC_NPINS];
	pbc_pad_drive_t          next_padDrive;
	logic [`PBC_NPINS-1:0]   next_gpioIn;
	logic [`PBC_NB-1:0]      next_periphIn;
	logic [`PBC_NB-1:0]      next_extDataHiIn;
	logic [`PBC_NB-1:0]      perDatVec;
	logic [`PBC_NB-1:0]      perOeVec;

	// Per-group mux results, joined into the pad vectors further down
	logic [`PBC_NB-1:0]      bDat;
	logic [`PBC_NB-1:0]      bOe;
	logic [`PBC_NB-1:0]      bGin;
	logic [`PBC_NCLO-1:0]    cloDat;
	logic [`PBC_NCLO-1:0]    cloOe;
	logic [`PBC_NCLO-1:0]    cloGin;
	logic [`PBC_NCUP-1:0]    cupDat;
	logic [`PBC_NCUP-1:0]    cupOe;
	logic [`PBC_NCUP-1:0]    cupGin;

	// Encoder inputs A and B are input only; held as a vector so it can be indexed
	localparam logic [`PBC_NB-1:0] inOnlyPins = `PBC_PER_IN_ONLY;

	assign perDatVec = periphDat;
	assign perOeVec  = periphOe;

	// =================================================================
	// AHB-Lite address phase: zero wait states, so every phase is taken
	assign addrAccept = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready;

	// Data phase write flag, a write lands at the end of its data phase
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dphWrite <= 1'b0;
		end else begin
			dphWrite <= addrAccept & ahbReq.hwrite;
		end
	end

	// Data phase address, held until the next accepted address phase
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			dphAddr <= '0;
		end else if (addrAccept) begin
			dphAddr <= ahbReq.haddr[`PBC_ADDR_W-1:0];
		end
	end

	// Next register values; reads use these so a read right behind a write sees it
	always_comb begin
		next_portBUpper = portBUpperFunctionSelect;
		if (dphWrite && dphAddr == `PBC_OFF_PORTB_UPPER) begin
			next_portBUpper = ahbReq.hwdata;
		end
	end

	// Port C lower next value
	always_comb begin
		next_portCLower = portCLowerFunctionSelect;
		if (dphWrite && dphAddr == `PBC_OFF_PORTC_LOWER) begin
			next_portCLower = ahbReq.hwdata;
		end
	end

	// Port C upper next value, reserved half masked before it is stored
	always_comb begin
		next_portCUpper = portCUpperFunctionSelect;
		if (dphWrite && dphAddr == `PBC_OFF_PORTC_UPPER) begin
			next_portCUpper = ahbReq.hwdata & `PBC_CU_WMASK;
		end
	end

	// Port B upper select, all fields back to GPIO at reset
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			portBUpperFunctionSelect <= `PBC_RST_PORTB_UPPER;
		end else begin
			portBUpperFunctionSelect <= next_portBUpper;
		end
	end

	// Port C lower select
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			portCLowerFunctionSelect <= `PBC_RST_PORTC_LOWER;
		end else begin
			portCLowerFunctionSelect <= next_portCLower;
		end
	end

	// Port C upper select, reserved half never stored
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			portCUpperFunctionSelect <= `PBC_RST_PORTC_UPPER;
		end else begin
			portCUpperFunctionSelect <= next_portCUpper;
		end
	end

	// Read data chosen in the address phase; unmapped offsets read zero
	always_comb begin
		case (ahbReq.haddr[`PBC_ADDR_W-1:0])
			`PBC_OFF_PORTB_UPPER: next_rdata = next_portBUpper;
			`PBC_OFF_PORTC_LOWER: next_rdata = next_portCLower;
			`PBC_OFF_PORTC_UPPER: next_rdata = next_portCUpper;
			default:              next_rdata = 32'h00000000;
		endcase
	end

	// Response flops: always ready, always OKAY
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			ahbRsp.hrdata    <= 32'h00000000;
			ahbRsp.hreadyout <= 1'b1;
			ahbRsp.hresp     <= 1'b0;
		end else begin
			ahbRsp.hreadyout <= 1'b1;
			ahbRsp.hresp     <= 1'b0;
			if (addrAccept && !ahbReq.hwrite) begin
				ahbRsp.hrdata <= next_rdata;
			end
		end
	end

	// =================================================================
	// Pad input synchroniser, first stage; may go metastable, so nothing else reads it
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			padInMeta <= '0;
		end else begin
			padInMeta <= padIn;
		end
	end

	// Second stage; only this one feeds the mux
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			padInSync <= '0;
		end else begin
			padInSync <= padInMeta;
		end
	end

	// =================================================================
	// Pin index map: 0..10 are pins 48..58, 11..26 pins 64..79, 27..29 pins 85..87.
	// Pins 59..63 and 80..84 keep their storage but steer nothing here.
	always_comb begin
		// Port B upper fields start at bit 0
		for (int i = 0; i < `PBC_NB; i++) begin
			pinSel[i] = portBUpperFunctionSelect[2*i +: 2];
		end
		// Port C lower fields start at bit 0
		for (int i = 0; i < `PBC_NCLO; i++) begin
			pinSel[`PBC_CLO_BASE+i] = portCLowerFunctionSelect[2*i +: 2];
		end
		// Port C upper fields start above the unused pins 80..84
		for (int i = 0; i < `PBC_NCUP; i++) begin
			pinSel[`PBC_CUP_BASE+i] = portCUpperFunctionSelect[`PBC_CU_FIRST_LSB+2*i +: 2];
		end
	end

	// =================================================================
	// Function mux, one process per port C group and two for port B. Functions that do not own a
	// pin see a constant zero from it, so a stale level never leaks across.

	// Port B upper drive: GPIO, a peripheral, or external data lines 31..21
	always_comb begin
		bDat = '0;
		bOe  = '0;
		for (int i = 0; i < `PBC_NB; i++) begin
			if (pinSel[i][`PBC_SEL_EXT_BIT]) begin
				// Pin 48 is line 31, pin 58 is line 21
				bDat[i] = extDataHi.dat[`PBC_NB-1-i];
				bOe[i]  = extDataHi.oe[`PBC_NB-1-i];
			end else if (pinSel[i] == `PBC_SEL_PERIPH) begin
				// Encoder inputs A and B never drive the pad
				bDat[i] = perDatVec[i];
				bOe[i]  = perOeVec[i] & ~inOnlyPins[i];
			end else begin
				bDat[i] = gpioDrive.dat[i];
				bOe[i]  = gpioDrive.oe[i];
			end
		end
	end

	// Port B input routing back to the function that owns each pin
	always_comb begin
		bGin             = '0;
		next_periphIn    = '0;
		next_extDataHiIn = '0;
		for (int i = 0; i < `PBC_NB; i++) begin
			if (pinSel[i][`PBC_SEL_EXT_BIT]) begin
				next_extDataHiIn[`PBC_NB-1-i] = padInSync[i];
			end else if (pinSel[i] == `PBC_SEL_PERIPH) begin
				next_periphIn[i] = padInSync[i];
			end else begin
				bGin[i] = padInSync[i];
			end
		end
	end

	// Port C lower: GPIO, or external data lines 15..0 as outputs only
	always_comb begin
		cloDat = '0;
		cloOe  = '0;
		cloGin = '0;
		for (int k = 0; k < `PBC_NCLO; k++) begin
			if (pinSel[`PBC_CLO_BASE+k][`PBC_SEL_EXT_BIT]) begin
				// Pin 64 is line 15, pin 79 is line 0
				cloDat[k] = extDataLoDat[`PBC_NCLO-1-k];
				cloOe[k]  = 1'b1;
			end else begin
				// Select 01 behaves like 00 on this port
				cloDat[k] = gpioDrive.dat[`PBC_CLO_BASE+k];
				cloOe[k]  = gpioDrive.oe[`PBC_CLO_BASE+k];
				cloGin[k] = padInSync[`PBC_CLO_BASE+k];
			end
		end
	end

	// Port C upper: GPIO, or address lines 13..15 as outputs only
	always_comb begin
		cupDat = '0;
		cupOe  = '0;
		cupGin = '0;
		for (int k = 0; k < `PBC_NCUP; k++) begin
			if (pinSel[`PBC_CUP_BASE+k][`PBC_SEL_EXT_BIT]) begin
				// Pins 85..87 are address lines 13..15
				cupDat[k] = extAddrDat[k];
				cupOe[k]  = 1'b1;
			end else begin
				// Select 01 behaves like 00 on this port
				cupDat[k] = gpioDrive.dat[`PBC_CUP_BASE+k];
				cupOe[k]  = gpioDrive.oe[`PBC_CUP_BASE+k];
				cupGin[k] = padInSync[`PBC_CUP_BASE+k];
			end
		end
	end

	// Pads are numbered from pin 48 up, port B in the low bits
	assign next_padDrive = {cupDat, cloDat, bDat, cupOe, cloOe, bOe};
	assign next_gpioIn   = {cupGin, cloGin, bGin};

	// =================================================================
	// Pad drive flops: cost one cycle of latency but keep pad timing clean
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			padDrive <= '0;
		end else begin
			padDrive <= next_padDrive;
		end
	end

	// GPIO input flops, zero for pins owned by another function
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			gpioIn <= '0;
		end else begin
			gpioIn <= next_gpioIn;
		end
	end

	// Peripheral input flops
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			periphIn <= '0;
		end else begin
			periphIn <= next_periphIn;
		end
	end

	// External data input flops for lines 21..31
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			extDataHiIn <= '0;
		end else begin
			extDataHiIn <= next_extDataHiIn;
		end
	end

endmodule : pbc_pin_mux

//--- pbc_consts.svh
// Constants for the port B/C pin function multiplexer: offsets, field layout, resets.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PBC_CONSTS_SVH
`define PBC_CONSTS_SVH

// =====================================================================
// Register map (byte offsets on the AHB-Lite slave)
`define PBC_ADDR_W           12
`define PBC_OFF_PORTB_UPPER  12'h000
`define PBC_OFF_PORTC_LOWER  12'h004
`define PBC_OFF_PORTC_UPPER  12'h008

// =====================================================================
// Reset values
`define PBC_RST_PORTB_UPPER  32'h00000000
`define PBC_RST_PORTC_LOWER  32'h00000000
`define PBC_RST_PORTC_UPPER  32'h00000000

// =====================================================================
// Field layout and select encodings
`define PBC_SEL_W            2
`define PBC_SEL_GPIO         2'h0
`define PBC_SEL_PERIPH       2'h1
`define PBC_SEL_EXT_BIT      1
`define PBC_CU_FIRST_LSB     10
`define PBC_CU_WMASK         32'h0000ffff
`define PBC_PER_IN_ONLY      11'h00c

// =====================================================================
// Pin grouping: index 0..10 port B 48..58, 11..26 port C 64..79, 27..29 port C 85..87
`define PBC_NPINS            30
`define PBC_NB               11
`define PBC_NCLO             16
`define PBC_NCUP             3
`define PBC_CLO_BASE         11
`define PBC_CUP_BASE         27

`endif

//--- pbc_pkg.sv
// Types shared by the pin function multiplexer and its surroundings.
// Assumes pbc_consts.svh is on the include path.
`include "pbc_consts.svh"

package pbc_pkg;

	// =================================================================
	// Pad drive bundle, one bit per muxed pin
	typedef struct packed {
		logic [`PBC_NPINS-1:0] dat;
		logic [`PBC_NPINS-1:0] oe;
	} pbc_pad_drive_t;

	// =================================================================
	// Peripheral signals on port B upper, bit 0 belongs to pin 48
	typedef struct packed {
		logic serialPortARxClock;
		logic spiASlaveTxEnable;
		logic spiAClock;
		logic spiASlaveOut;
		logic spiASlaveIn;
		logic encoder1Index;
		logic encoder1Strobe;
		logic encoder1InputB;
		logic encoder1InputA;
		logic captureChannel6;
		logic captureChannel5;
	} pbc_periph_t;

	// =================================================================
	// External data lines 21..31, bit 0 is line 21
	typedef struct packed {
		logic [`PBC_NB-1:0] dat;
		logic [`PBC_NB-1:0] oe;
	} pbc_ext_hi_t;

	// =================================================================
	// AHB-Lite request and response
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic [31:0] hwdata;
		logic        hready;
	} pbc_ahb_req_t;

	typedef struct packed {
		logic [31:0] hrdata;
		logic        hreadyout;
		logic        hresp;
	} pbc_ahb_rsp_t;

endpackage : pbc_pkg

//--- pbc_pin_mux_monitor.sv
// Checker for the port B/C pin function multiplexer, bound to pbc_pin_mux.
// Assumes one AHB-Lite master and zero wait states on the slave.
`timescale 1ns/1ps
`include "pbc_consts.svh"
module pbc_pin_mux_monitor
	import pbc_pkg::*;
(
	input wire logic                  mclk,
	input wire logic                  arst_n,
	input wire pbc_ahb_req_t          ahbReq,
	input wire pbc_ahb_rsp_t          ahbRsp,
	input wire pbc_pad_drive_t        gpioDrive,
	input wire logic [`PBC_NPINS-1:0] gpioIn,
	input wire pbc_periph_t           periphDat,
	input wire pbc_periph_t           periphOe,
	input wire pbc_periph_t           periphIn,
	input wire pbc_ext_hi_t           extDataHi,
	input wire logic [`PBC_NCLO-1:0]  extDataLoDat,
	input wire logic [`PBC_NCUP-1:0]  extAddrDat,
	input wire logic [`PBC_NPINS-1:0] padIn,
	input wire pbc_pad_drive_t        padDrive
);
	// ====
	// Shadow registers
	logic [31:0]    shB, shC, shU, rdv;
	logic [11:0]    wa;
	logic           wp, rdTk, ok;
	logic [1:0]     up;
	pbc_pad_drive_t expD;
	logic [29:0]    gMask;
	logic [10:0]    pMask;
	assign rdTk = ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready & !ahbReq.hwrite;
	// Pipelined pads need three edges after reset before past values mean anything
	assign ok = up == 2'h3;
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			{shB, shC, shU, wa, wp, up} <= '0;
		end else begin
			wp <= ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hready & ahbReq.hwrite;
			wa <= ahbReq.haddr[11:0];
			up <= ok ? up : up + 2'h1;
			if (wp && wa == `PBC_OFF_PORTB_UPPER) shB <= ahbReq.hwdata;
			if (wp && wa == `PBC_OFF_PORTC_LOWER) shC <= ahbReq.hwdata;
			if (wp && wa == `PBC_OFF_PORTC_UPPER) shU <= ahbReq.hwdata;
		end
	end
	// Expected read data and pad routing from the shadow
	always_comb begin
		case (wa)
			`PBC_OFF_PORTB_UPPER: rdv = shB;
			`PBC_OFF_PORTC_LOWER: rdv = shC;
			`PBC_OFF_PORTC_UPPER: rdv = shU & 32'h0000ffff;
			default: rdv = 32'h0;
		endcase
		expD = gpioDrive;
		gMask = '1;
		pMask = '0;
		for (int i = 0; i < 11; i++) begin
			if (shB[2*i+:2] == 2'h1) begin
				expD.dat[i] = periphDat[i];
				expD.oe[i] = periphOe[i] && i != 2 && i != 3;
				pMask[i] = 1'b1;
				gMask[i] = 1'b0;
			end else if (shB[2*i+1]) begin
				expD.dat[i] = extDataHi.dat[10-i];
				expD.oe[i] = extDataHi.oe[10-i];
				gMask[i] = 1'b0;
			end
		end
		for (int k = 0; k < 19; k++) begin
			if (k < 16 ? shC[2*k+1] : shU[2*k-21]) begin
				expD.dat[11+k] = k < 16 ? extDataLoDat[15-k] : extAddrDat[k-16];
				expD.oe[11+k] = 1'b1;
				gMask[11+k] = 1'b0;
			end
		end
	end
	// ====
	// Properties
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);
	sequence s_rdAddr;
		rdTk;
	endsequence
	sequence s_rdData;
		##1 ahbRsp.hrdata == rdv;
	endsequence
	property p_rd;
		s_rdAddr |-> s_rdData;
	endproperty
	a_rd: assert property (p_rd) else $error("read data wrong");
	property p_stand;
		!rdTk |=> $stable(ahbRsp.hrdata);
	endproperty
	a_stand: assert property (p_stand) else $error("read data moved");
	property p_rsp;
		ahbRsp.hreadyout && !ahbRsp.hresp;
	endproperty
	a_rsp: assert property (p_rsp) else $error("bus response wrong");
	property p_pb;
		ok |-> {padDrive.dat[10:0], padDrive.oe[10:0]} == $past({expD.dat[10:0], expD.oe[10:0]});
	endproperty
	a_pb: assert property (p_pb) else $error("port B pads wrong");
	property p_pc;
		ok |-> {padDrive.dat[26:11], padDrive.oe[26:11]} == $past({expD.dat[26:11], expD.oe[26:11]});
	endproperty
	a_pc: assert property (p_pc) else $error("port C lower pads wrong");
	property p_pu;
		ok |-> {padDrive.dat[29:27], padDrive.oe[29:27]} == $past({expD.dat[29:27], expD.oe[29:27]});
	endproperty
	a_pu: assert property (p_pu) else $error("port C upper pads wrong");
	property p_in;
		ok && shB[7:4] == 4'h5 |=> padDrive.oe[3:2] == 2'h0;
	endproperty
	a_in: assert property (p_in) else $error("input-only pin driven");
	property p_gin;
		ok |-> gpioIn == ($past(padIn, 3) & $past(gMask));
	endproperty
	a_gin: assert property (p_gin) else $error("gpio input wrong");
	property p_pin;
		ok |-> periphIn == ($past(padIn[10:0], 3) & $past(pMask));
	endproperty
	a_pin: assert property (p_pin) else $error("peripheral input wrong");
endmodule : pbc_pin_mux_monitor

bind pbc_pin_mux pbc_pin_mux_monitor i_pbc_pin_mux_monitor (.mclk, .arst_n, .ahbReq, .ahbRsp,
	.gpioDrive, .gpioIn, .periphDat, .periphOe, .periphIn, .extDataHi, .extDataLoDat,
	.extAddrDat, .padIn, .padDrive);

//--- pbc_far_side.sv
// Stand-in for the peripherals and external memory interface.
// Assumes the bench only samples pads after they settle.
`timescale 1ns/1ps
module pbc_far_side
	import pbc_pkg::*;
(
	output pbc_periph_t periphDat,
	output pbc_periph_t periphOe,
	output pbc_ext_hi_t extDataHi,
	output logic [15:0] extDataLoDat,
	output logic [2:0]  extAddrDat
);
	// Asymmetric patterns on the data lines, so a swapped line order shows at those pads; the address pattern 3'h5 is symmetric
	assign periphDat = 11'h5a5;
	assign periphOe = 11'h7ff;
	assign extDataHi = {11'h3c3, 11'h70f};
	assign extDataLoDat = 16'hc35a;
	assign extAddrDat = 3'h5;
endmodule : pbc_far_side

//--- port_b_c_pin_function_mux_tb_top.sv
// Bench: AHB-Lite register access and pad routing for each select value.
// Assumes pbc_far_side and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "pbc_consts.svh"
module port_b_c_pin_function_mux_tb_top
	import pbc_pkg::*;
;
	localparam logic [11:0] OFFS [4] = '{`PBC_OFF_PORTB_UPPER, `PBC_OFF_PORTC_LOWER,
		`PBC_OFF_PORTC_UPPER, 12'h00c};
	localparam logic [31:0] RBK [4] = '{32'hffffffff, 32'hffffffff, 32'h0000ffff, 32'h0};
	localparam logic [31:0] BSEL [2] = '{32'h002aaaaa, 32'h003fffff};
	localparam logic [31:0] CSEL [3] = '{32'h55555555, 32'haaaaaaaa, 32'hffffffff};
	localparam logic [31:0] USEL [3] = '{32'h00005400, 32'h0000a800, 32'h0000fc00};
	logic           mclk, arst_n;
	pbc_ahb_req_t   ahbReq;
	pbc_ahb_rsp_t   ahbRsp;
	pbc_pad_drive_t gpioDrive, padDrive;
	logic [29:0]    gpioIn, padIn;
	pbc_periph_t    periphDat, periphOe, periphIn;
	pbc_ext_hi_t    extDataHi;
	logic [10:0]    extDataHiIn;
	logic [15:0]    extDataLoDat;
	logic [2:0]     extAddrDat;
	logic [31:0]    rd;
	int             mismatches, n_checks;
	// Single slave, so its ready is the bus ready
	assign ahbReq.hready = ahbRsp.hreadyout;
	pbc_pin_mux i_pbc_pin_mux (.mclk, .arst_n, .ahbReq, .ahbRsp, .gpioDrive, .gpioIn,
		.periphDat, .periphOe, .periphIn, .extDataHi, .extDataHiIn, .extDataLoDat,
		.extAddrDat, .padIn, .padDrive);
	pbc_far_side i_pbc_far_side (.periphDat, .periphOe, .extDataHi, .extDataLoDat, .extAddrDat);
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// ====
	// Tasks
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// Bounded wait for hready, a hang ends the run
	task automatic waitRdy();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (ahbRsp.hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			mismatches++;
			give_verdict();
		end
	endtask : waitRdy
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		ahbReq.haddr <= {20'h0, a};
		ahbReq.hwrite <= w;
		ahbReq.htrans <= 2'h2;
		waitRdy();
		ahbReq.htrans <= 2'h0;
		ahbReq.hwdata <= d;
		waitRdy();
		rd = ahbRsp.hrdata;
	endtask : bus
	// Four edges cover the register, sync and output flop latency
	task automatic mode(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		repeat (4) @(posedge mclk);
	endtask : mode
	task automatic defaults();
		foreach (OFFS[i]) begin
			bus(1'b0, OFFS[i], 32'h0);
			chk("rst", rd, 32'h0);
		end
		chk("pad", padDrive, gpioDrive);
		chk("gin", gpioIn, padIn);
	endtask : defaults
	// ====
	// Main sequence
	initial begin
		arst_n = 1'b0;
		{ahbReq.hsel, ahbReq.haddr, ahbReq.htrans, ahbReq.hwrite} = {1'b1, 32'h0, 2'h0, 1'b0};
		{ahbReq.hsize, ahbReq.hwdata} = {3'h2, 32'h0};
		gpioDrive = {30'h12345678, 30'h0f0f0f0f};
		padIn = 30'h2a5a5003;
		mismatches = 0;
		n_checks = 0;
		repeat (6) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		defaults();
		mode(`PBC_OFF_PORTB_UPPER, 32'h00155555);
		chk("pbd", padDrive.dat[10:0], 11'h5a5);
		chk("pbo", padDrive.oe[10:0], 11'h7f3);
		chk("pbi", periphIn, padIn[10:0]);
		chk("pbg", gpioIn[10:0], 11'h0);
		foreach (BSEL[i]) begin
			mode(`PBC_OFF_PORTB_UPPER, BSEL[i]);
			chk("pxd", padDrive.dat[10:0], 11'h61e);
			chk("pxo", padDrive.oe[10:0], 11'h787);
			chk("pxi", extDataHiIn, 11'h600);
		end
		for (int i = 0; i < 3; i++) begin
			mode(`PBC_OFF_PORTC_LOWER, CSEL[i]);
			mode(`PBC_OFF_PORTC_UPPER, USEL[i]);
			chk("pcd", padDrive.dat[26:11], i ? 16'h5ac3 : gpioDrive.dat[26:11]);
			chk("pco", padDrive.oe[26:11], i ? 16'hffff : gpioDrive.oe[26:11]);
			chk("pcg", gpioIn[26:11], i ? 16'h0 : padIn[26:11]);
			chk("pud", padDrive.dat[29:27], i ? 3'h5 : gpioDrive.dat[29:27]);
			chk("puo", padDrive.oe[29:27], i ? 3'h7 : gpioDrive.oe[29:27]);
		end
		foreach (OFFS[i]) begin
			bus(1'b1, OFFS[i], 32'hffffffff);
			bus(1'b0, OFFS[i], 32'h0);
			chk("rbk", rd, RBK[i]);
		end
		arst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		arst_n <= 1'b1;
		@(posedge mclk);
		defaults();
		give_verdict();
	end
endmodule : port_b_c_pin_function_mux_tb_top
